/* logic/ucen_map.svh */
// Register offsets, field positions and counts of the port control block
// How it works
// - CTS enable gates transmit start on CTS
// - RTS enable requests data while FIFO has room
// - Aux pin B is inverse of bit 13
// - Aux pin A is inverse of bit 12
// - RTS pin is inverse of bit 11
// - DTR pin is inverse of bit 10
// - Bit 9 enables receive, resets to one
// - Bit 8 enables transmit, resets to one
// - Disabling finishes the character in progress
// - IR loopback feeds IR output back, not inverted
// - Serial loopback feeds transmit into receive
// - Loopback feeds modem outputs to inputs
// - Normal IR pulse is three sixteenths bit
// - Low-power IR pulse is three reference periods
// - IR disabled holds output low, ignores input
// - IR enabled moves data to IR pins
// - IR mode marks serial out, ignores inputs
// - IR enable ignored while port disabled and idle
// - Bit 0 enables the port, resets zero
`ifndef UCEN_MAP_SVH
`define UCEN_MAP_SVH
// Byte offsets on the register port
`define UCEN_CR_OFF      12'h030
`define UCEN_ST_OFF      12'h040
`define UCEN_TC_OFF      12'h080
// Reset values and writable masks
`define UCEN_CR_RESET    32'h00000300
`define UCEN_CR_WMASK    32'h0000ff87
`define UCEN_TC_RESET    32'h00000000
`define UCEN_TC_WMASK    32'h00000001
// Control field positions
`define UCEN_CR_TXFLOW   15
`define UCEN_CR_RXFLOW   14
`define UCEN_CR_OUT_B    13
`define UCEN_CR_OUT_A    12
`define UCEN_CR_RTS      11
`define UCEN_CR_DTR      10
`define UCEN_CR_RXEN     9
`define UCEN_CR_TXEN     8
`define UCEN_CR_LOOP     7
`define UCEN_CR_LP       2
`define UCEN_CR_SIR      1
`define UCEN_CR_EN       0
`define UCEN_TC_IRTEST   0
// Synchronised pin positions and idle levels
`define UCEN_PIN_RXD     0
`define UCEN_PIN_CTS     1
`define UCEN_PIN_DSR     2
`define UCEN_PIN_DCD     3
`define UCEN_PIN_RI      4
`define UCEN_PIN_IRRX    5
`define UCEN_PIN_LPB     6
`define UCEN_PIN_IDLE    7'h1f
// Infrared pulse and stretch lengths in units
`define UCEN_IR_PULSE    2'd3
`define UCEN_IR_STRETCH  5'd16
`endif

/* logic/ucen_pkg.sv */
// Types shared by the port control block
package ucen_pkg;
  // One register word
  typedef logic [31:0] word_t;
  // Infrared encoder states
  typedef enum logic [0:0] {IR_IDLE, IR_PULSE} irTxState_e;
endpackage : ucen_pkg

/* logic/ucen_control.sv */
// Control enables, modem pins, loopback and infrared coding of the port
`include "ucen_map.svh"

module ucen_control (
  // Clock, reset and freeze
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Register port
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Serial core, same clock
  input  wire logic        coreTxBit,
  input  wire logic        coreTxBusy,
  input  wire logic        coreRxBusy,
  input  wire logic        coreBitStart,
  input  wire logic        baud16Tick,
  input  wire logic        rxFifoRoom,
  output logic             coreTxStartOk,
  output logic             coreRxStartOk,
  output logic             coreTxRun,
  output logic             coreRxRun,
  output logic             coreRxBit,
  output logic      [3:0]  coreModemSt,
  // Plain serial and modem pins
  output logic             serialTxPin,
  input  wire logic        serialRxPin,
  input  wire logic        clearToSendN,
  input  wire logic        dataSetReadyN,
  input  wire logic        carrierDetectN,
  input  wire logic        ringIndicateN,
  output logic             requestToSendN,
  output logic             terminalReadyN,
  output logic             auxModemPinAN,
  output logic             auxModemPinBN,
  // Infrared pins
  output logic             infraredTxN,
  input  wire logic        infraredRx,
  input  wire logic        lowPowerBaudRef
);

  // Pick one bit of a register word
  function automatic logic bitOf(input ucen_pkg::word_t w,
                                 input int unsigned pos);
    bitOf = w[pos];
  endfunction : bitOf

  // Registers seen by software
  ucen_pkg::word_t         ctrl_q;     // Port control
  ucen_pkg::word_t         test_q;     // Test control
  ucen_pkg::word_t         rdata_q;    // Read data stage

  // Pin synchronisers
  logic [6:0]              pinRaw;     // Raw pin bundle
  logic [6:0]              pinS1_q;    // First stage, read by S2 only
  logic [6:0]              pinS2_q;    // Second stage
  logic [6:0]              pinS3_q;    // Third stage
  logic [6:0]              pinF_q;     // Agreed pin levels

  // Decoded control fields
  logic                    portEn;
  logic                    txEnBit;
  logic                    rxEnBit;
  logic                    loopBit;
  logic                    lpBit;
  logic                    sirBit;
  logic                    ctsEnBit;
  logic                    rtsEnBit;
  logic                    irTest;

  // Mode and routing
  logic                    portLive;   // Enabled or finishing a character
  logic                    sirActive;  // Infrared path in use
  logic                    serialLoop; // Transmit fed to receive
  logic                    irLoop;     // IR output fed to IR input
  logic [3:0]              modemSt;    // Active-high cts,dsr,dcd,ri
  logic                    ctsOk;      // Transmit may start

  // Infrared encoder
  ucen_pkg::irTxState_e    irSt_q;
  logic [1:0]              irCnt_q;    // Units elapsed in pulse
  logic                    irPulse;    // Light pulse active
  logic                    lpPrev_q;   // Low-power ref last level
  logic                    lpEdge;     // Low-power ref rising edge
  logic                    irUnit;     // Pulse time unit

  // Infrared decoder
  logic                    irIn;       // Selected IR input
  logic                    irPrev_q;
  logic                    irRise;
  logic [4:0]              stretch_q;  // Decoded low bit length
  logic                    irRxBit;

  // Field decode
  assign portEn   = bitOf(ctrl_q, `UCEN_CR_EN);
  assign txEnBit  = bitOf(ctrl_q, `UCEN_CR_TXEN);
  assign rxEnBit  = bitOf(ctrl_q, `UCEN_CR_RXEN);
  assign loopBit  = bitOf(ctrl_q, `UCEN_CR_LOOP);
  assign lpBit    = bitOf(ctrl_q, `UCEN_CR_LP);
  assign sirBit   = bitOf(ctrl_q, `UCEN_CR_SIR);
  assign ctsEnBit = bitOf(ctrl_q, `UCEN_CR_TXFLOW);
  assign rtsEnBit = bitOf(ctrl_q, `UCEN_CR_RXFLOW);
  assign irTest   = bitOf(test_q, `UCEN_TC_IRTEST);

  // Control register, reserved bits never stored
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ctrl_q <= `UCEN_CR_RESET;
    else if (ce && regWr && regAddr == `UCEN_CR_OFF)
      ctrl_q <= regWdata & `UCEN_CR_WMASK;
  end

  // Test register holding the infrared test bit
  always_ff @(posedge core_clk)
  begin
    if (rst)
      test_q <= `UCEN_TC_RESET;
    else if (ce && regWr && regAddr == `UCEN_TC_OFF)
      test_q <= regWdata & `UCEN_TC_WMASK;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else if (ce)
    begin
      if (!regRd)
        rdata_q <= 32'h00000000;
      else if (regAddr == `UCEN_CR_OFF)
        rdata_q <= ctrl_q;
      else if (regAddr == `UCEN_TC_OFF)
        rdata_q <= test_q;
      else if (regAddr == `UCEN_ST_OFF)
        rdata_q <= {25'h0, sirActive, coreRxBusy, coreTxBusy,
                    modemSt};
      else
        rdata_q <= 32'h00000000; // Unmapped reads as zero
    end
  end
  assign regRdata = rdata_q;

  // Pins cross in through three stages
  assign pinRaw = {lowPowerBaudRef, infraredRx, ringIndicateN,
                   carrierDetectN, dataSetReadyN, clearToSendN,
                   serialRxPin};

  // Synchroniser chain
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pinS1_q <= `UCEN_PIN_IDLE;
      pinS2_q <= `UCEN_PIN_IDLE;
      pinS3_q <= `UCEN_PIN_IDLE;
    end
    else if (ce)
    begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // A level counts once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pinF_q <= `UCEN_PIN_IDLE;
    else if (ce)
      pinF_q <= (pinS2_q & ~(pinS2_q ^ pinS3_q)) |
                (pinF_q & (pinS2_q ^ pinS3_q));
  end

  // Routing stays put while a character drains
  assign portLive   = portEn | coreTxBusy | coreRxBusy;
  assign sirActive  = sirBit & portLive;
  assign serialLoop = loopBit & ~irTest;
  assign irLoop     = loopBit & sirBit & irTest;

  // Modem status seen by the core
  always_comb
  begin
    if (sirActive)
      modemSt = 4'h0;
    else if (loopBit)
      modemSt = {bitOf(ctrl_q, `UCEN_CR_OUT_B),
                 bitOf(ctrl_q, `UCEN_CR_OUT_A),
                 bitOf(ctrl_q, `UCEN_CR_DTR),
                 bitOf(ctrl_q, `UCEN_CR_RTS)};
    else
      modemSt = ~pinF_q[`UCEN_PIN_RI:`UCEN_PIN_CTS];
  end

  // Flow control only holds back the next start
  assign ctsOk = ~ctsEnBit | modemSt[0];

  // Start and run enables to the core
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      coreTxStartOk <= 1'b0;
      coreRxStartOk <= 1'b0;
      coreTxRun     <= 1'b0;
      coreRxRun     <= 1'b0;
      coreModemSt   <= 4'h0;
    end
    else if (ce)
    begin
      coreTxStartOk <= portEn & txEnBit & ctsOk;
      coreRxStartOk <= portEn & rxEnBit;
      // A busy section keeps running until its character ends
      coreTxRun     <= (portEn & txEnBit) | coreTxBusy;
      coreRxRun     <= (portEn & rxEnBit) | coreRxBusy;
      coreModemSt   <= modemSt;
    end
  end

  // Low-power reference edge from the agreed level
  assign lpEdge = pinF_q[`UCEN_PIN_LPB] & ~lpPrev_q;
  assign irUnit = lpBit ? lpEdge : baud16Tick;
  // Count zero is the low-power wait for a reference edge, kept dark
  assign irPulse = (irSt_q == ucen_pkg::IR_PULSE) && (irCnt_q != 2'd0);

  // Reference edge tracker
  always_ff @(posedge core_clk)
  begin
    if (rst)
      lpPrev_q <= 1'b0;
    else if (ce)
      lpPrev_q <= pinF_q[`UCEN_PIN_LPB];
  end

  // Encoder: one pulse of three units per low bit
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irSt_q  <= ucen_pkg::IR_IDLE;
      irCnt_q <= 2'd0;
    end
    else if (ce)
    begin
      unique case (irSt_q)
        ucen_pkg::IR_IDLE:
        begin
          // Bit start is a baud tick, so the pulse is whole units
          if (sirActive && coreBitStart && !coreTxBit)
          begin
            irSt_q  <= ucen_pkg::IR_PULSE;
            // Low power starts on a reference edge: three whole periods
            irCnt_q <= lpBit ? 2'd0 : 2'd1;
          end
        end
        ucen_pkg::IR_PULSE:
        begin
          if (irUnit)
          begin
            if (irCnt_q == `UCEN_IR_PULSE)
              irSt_q <= ucen_pkg::IR_IDLE;
            else
              irCnt_q <= irCnt_q + 2'd1;
          end
        end
      endcase
    end
  end

  // Decoder input, internal loop when testing
  assign irIn   = irLoop ? irPulse : pinF_q[`UCEN_PIN_IRRX];
  assign irRise = sirActive & irIn & ~irPrev_q;

  // Input edge tracker
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irPrev_q <= 1'b0;
    else if (ce)
      irPrev_q <= irIn;
  end

  // Stretch each received pulse to one bit period
  always_ff @(posedge core_clk)
  begin
    if (rst)
      stretch_q <= 5'd0;
    else if (ce)
    begin
      if (irRise)
        stretch_q <= `UCEN_IR_STRETCH;
      else if (!sirActive)
        stretch_q <= 5'd0; // Leaving IR mode drops a stale bit
      else if (baud16Tick && stretch_q != 5'd0)
        stretch_q <= stretch_q - 5'd1;
    end
  end
  assign irRxBit = (stretch_q == 5'd0);

  // Receive bit to the core
  always_ff @(posedge core_clk)
  begin
    if (rst)
      coreRxBit <= 1'b1;
    else if (ce)
    begin
      if (sirActive)
        coreRxBit <= irRxBit;
      else if (serialLoop)
        coreRxBit <= coreTxBit;
      else
        coreRxBit <= pinF_q[`UCEN_PIN_RXD];
    end
  end

  // Line and modem output pins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      serialTxPin    <= 1'b1;
      infraredTxN    <= 1'b0;
      requestToSendN <= 1'b1;
      terminalReadyN <= 1'b1;
      auxModemPinAN  <= 1'b1;
      auxModemPinBN  <= 1'b1;
    end
    else if (ce)
    begin
      // Marking level keeps a listener idle in IR mode
      serialTxPin    <= sirActive ? 1'b1 : coreTxBit;
      // Light is the high level, so dark stays low
      infraredTxN    <= sirActive ? irPulse : 1'b0;
      // Flow control replaces the software RTS level
      if (rtsEnBit)
        requestToSendN <= ~rxFifoRoom;
      else
        requestToSendN <= ~bitOf(ctrl_q, `UCEN_CR_RTS);
      terminalReadyN <= ~bitOf(ctrl_q, `UCEN_CR_DTR);
      auxModemPinAN  <= ~bitOf(ctrl_q, `UCEN_CR_OUT_A);
      auxModemPinBN  <= ~bitOf(ctrl_q, `UCEN_CR_OUT_B);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Write lands with reserved bits cleared
  chk_cr_write_mask: assert property (
    ce && regWr && regAddr == `UCEN_CR_OFF
    |=> ctrl_q == ($past(regWdata) & `UCEN_CR_WMASK))
    else $error("control write not masked");

  // Reset value of the control word
  chk_cr_reset_val: assert property (
    $past(rst) |-> ctrl_q == `UCEN_CR_RESET)
    else $error("control reset value wrong");

  // CTS low blocks transmit start
  chk_cts_gate: assert property (
    ce && ctsEnBit && !modemSt[0] |=> !coreTxStartOk)
    else $error("transmit allowed without CTS");

  // Full FIFO deasserts RTS
  chk_rts_flow: assert property (
    ce && rtsEnBit && !rxFifoRoom |=> requestToSendN)
    else $error("RTS asserted with no room");

  // Modem pins follow inverted bits
  chk_modem_pins: assert property (
    ce && !rtsEnBit |=> requestToSendN == !$past(ctrl_q[11]) &&
      terminalReadyN == !$past(ctrl_q[10]) &&
      auxModemPinAN == !$past(ctrl_q[12]) &&
      auxModemPinBN == !$past(ctrl_q[13]))
    else $error("modem pin not inverse of bit");

  // Busy transmitter keeps running
  chk_finish_char: assert property (
    ce && coreTxBusy |=> coreTxRun)
    else $error("transmitter stopped mid character");

  // Disabled port starts nothing
  chk_port_gate: assert property (
    ce && !portEn |=> !coreTxStartOk && !coreRxStartOk)
    else $error("start allowed while disabled");

  // IR off holds output low
  chk_ir_off: assert property (
    ce && !sirActive |=> !infraredTxN && stretch_q == 5'd0)
    else $error("IR output active while disabled");

  // IR mode marks the serial pin
  chk_sir_mark: assert property (
    ce && sirActive |=> serialTxPin)
    else $error("serial pin not marking in IR mode");

  // Pulse ends after the third unit
  chk_pulse_len: assert property (
    ce && irPulse && irUnit && irCnt_q == 2'd3 |=> !irPulse)
    else $error("IR pulse too long");

  // Serial loopback copies transmit bit
  chk_loop_serial: assert property (
    ce && !sirActive && serialLoop |=> coreRxBit == $past(coreTxBit))
    else $error("serial loopback broken");

  // Loopback ties modem status to outputs
  chk_loop_modem: assert property (
    ce && loopBit && !sirActive |=> coreModemSt ==
      {$past(ctrl_q[13]), $past(ctrl_q[12]),
       $past(ctrl_q[10]), $past(ctrl_q[11])})
    else $error("modem loopback broken");

  // IR loopback turns its own pulse into a received low bit
  chk_loop_ir: assert property (
    ce && irLoop && sirActive && irPulse && !irPrev_q
    |=> ##1 !coreRxBit)
    else $error("IR loopback broken");

  // Main scenarios
  cov_lp_pulse: cover property (ce && irPulse && lpBit);
  cov_serial_loop: cover property (ce && serialLoop && coreTxBusy);
  cov_disable_busy: cover property (ce && !portEn && coreTxBusy);
  cov_ir_receive: cover property (ce && irRise);

endmodule : ucen_control

/* sim/ucen_far_side.sv */
// Remote modem and infrared transceiver facing the port control block
module ucen_far_side #(
  parameter int LP_HALF = 5  // Half period of the low-power reference
) (
  // Clock
  input  wire logic       core_clk,
  // Bench commands, active high modem levels {ri,dcd,dsr,cts}
  input  wire logic [3:0] modemReq,
  input  wire logic       irFlash,
  // Pins towards the port
  output logic            clearToSendN,
  output logic            dataSetReadyN,
  output logic            carrierDetectN,
  output logic            ringIndicateN,
  output logic            serialRxPin,
  output logic            infraredRx,
  output logic            lowPowerBaudRef
);
  timeunit 1ns;
  timeprecision 1ns;
  int   lpCnt;   // Reference divider
  int   irLeft;  // Cycles left of a light pulse
  logic flashQ;  // Edge finder on the flash command

  // Idle line: marking serial input, dark receiver, modem lines off
  initial
  begin
    {ringIndicateN, carrierDetectN, dataSetReadyN, clearToSendN} = 4'hf;
    serialRxPin     = 1'b1;
    infraredRx      = 1'b0;
    lowPowerBaudRef = 1'b0;
    lpCnt           = 0;
    irLeft          = 0;
    flashQ          = 1'b0;
  end

  // Modem lines are active low on the wire
  always @(posedge core_clk)
    {ringIndicateN, carrierDetectN, dataSetReadyN, clearToSendN} <= ~modemReq;

  // Reference runs free, unrelated to the bit rate
  always @(posedge core_clk)
  begin
    lpCnt <= (lpCnt == LP_HALF - 1) ? 0 : lpCnt + 1;
    if (lpCnt == LP_HALF - 1)
      lowPowerBaudRef <= ~lowPowerBaudRef;
  end

  // Short active-high light pulse, long enough to pass the synchroniser
  always @(posedge core_clk)
  begin
    flashQ     <= irFlash;
    irLeft     <= (irFlash && !flashQ) ? 4 : (irLeft > 0 ? irLeft - 1 : 0);
    infraredRx <= (irFlash && !flashQ) || irLeft > 1;
  end
endmodule : ucen_far_side

/* sim/tb_top.sv */
// Self-checking bench of the port control block
`include "ucen_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, ce, regWr, regRd;  // Clock, reset, strobes
  logic [11:0] regAddr;                          // Register address
  logic [31:0] regWdata, regRdata, ctl, v;       // Data, control shadow
  logic        coreTxBit, coreTxBusy, coreRxBusy, coreBitStart;
  logic        baud16Tick, rxFifoRoom, txOk, rxOk, txRun, rxRun, rxBit;
  logic [3:0]  modemSt, modemReq, m;             // Modem status, stimulus
  logic        txPin, rxPin, ctsN, dsrN, dcdN, riN, rtsN, dtrN;
  logic        auxAN, auxBN, irTxN, irRx, lpRef, irFlash, rdPend;
  logic [1:0]  tickCnt;                          // Sixteenth-bit divider
  logic [31:0] expQ[$];                          // Expected read data
  int          failures, cmp_count, w, n;

  ucen_control DUT (
    .core_clk(core_clk), .rst(rst), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .coreTxBit(coreTxBit), .coreTxBusy(coreTxBusy),
    .coreRxBusy(coreRxBusy), .coreBitStart(coreBitStart),
    .baud16Tick(baud16Tick), .rxFifoRoom(rxFifoRoom),
    .coreTxStartOk(txOk), .coreRxStartOk(rxOk), .coreTxRun(txRun),
    .coreRxRun(rxRun), .coreRxBit(rxBit), .coreModemSt(modemSt),
    .serialTxPin(txPin), .serialRxPin(rxPin), .clearToSendN(ctsN),
    .dataSetReadyN(dsrN), .carrierDetectN(dcdN), .ringIndicateN(riN),
    .requestToSendN(rtsN), .terminalReadyN(dtrN), .auxModemPinAN(auxAN),
    .auxModemPinBN(auxBN), .infraredTxN(irTxN), .infraredRx(irRx),
    .lowPowerBaudRef(lpRef));

  ucen_far_side #(.LP_HALF(5)) FAR (
    .core_clk(core_clk), .modemReq(modemReq), .irFlash(irFlash),
    .clearToSendN(ctsN), .dataSetReadyN(dsrN), .carrierDetectN(dcdN),
    .ringIndicateN(riN), .serialRxPin(rxPin), .infraredRx(irRx),
    .lowPowerBaudRef(lpRef));

  // 25 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Sixteenth-bit tick on every fourth cycle
  always @(posedge core_clk)
  begin
    tickCnt    <= tickCnt + 2'd1;
    baud16Tick <= (tickCnt == 2'd3);
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    if (rdPend)
      cmp_word("regRdata", expQ.pop_front(), regRdata);
    rdPend <= regRd;
  end

  // Hang guard, far beyond the several hundred cycles the tests take
  initial
  begin
    #800000;
    failures++;
    complete_run();
  end

  task automatic cmp_word(string what, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : cmp_word

  task automatic cmp_bit(string what, logic e, logic s);
    cmp_word(what, {31'h0, e}, {31'h0, s});
  endtask : cmp_bit

  // Single-cycle write strobe
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask : wr

  // Single-cycle read strobe; the monitor does the comparison
  task automatic rd(logic [11:0] a, logic [31:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
  endtask : rd

  // Let the pin synchronisers catch up, then sample mid-cycle
  task automatic settle(int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic set_ctl(logic [31:0] d);
    wr(`UCEN_CR_OFF, d);
    ctl = d & `UCEN_CR_WMASK;
  endtask : set_ctl

  // Start one low bit on a tick, then count cycles of an active level
  task automatic ir_bit(int sel, int span, output int cnt);
    cnt = 0;
    do @(negedge core_clk); while (tickCnt !== 2'd3);
    @(posedge core_clk);
    coreBitStart <= 1'b1;
    @(posedge core_clk);
    coreBitStart <= 1'b0;
    repeat (span)
    begin
      @(negedge core_clk);
      if (sel == 0 ? irTxN === 1'b1 : rxBit === 1'b0)
        cnt++;
    end
  endtask : ir_bit

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    // Time-zero values, reset held two cycles
    {rst, ce, coreTxBit, rxFifoRoom} = 4'hf;
    {regWr, regRd, coreTxBusy, coreRxBusy, coreBitStart} = '0;
    {regAddr, regWdata, modemReq, irFlash, rdPend, tickCnt} = '0;
    baud16Tick = 1'b0;
    w = $urandom(13282);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    settle(0);
    cmp_bit("infraredTxN", 1'b0, irTxN);
    rd(`UCEN_CR_OFF, `UCEN_CR_RESET);
    rd(`UCEN_TC_OFF, 32'h0);
    rd(12'h0fc, 32'h0);
    // Random control words against pins, status and start permissions
    repeat (12)
    begin
      v = $urandom;
      w = $urandom;
      if (v[7])
        v[14] = 1'b0;  // Loopback path shows the plain control bit
      @(posedge core_clk);
      modemReq   <= w[3:0];
      rxFifoRoom <= w[4];
      set_ctl(v);
      rd(`UCEN_CR_OFF, ctl);
      settle(8);
      m = (ctl[1] & ctl[0]) ? 4'h0 :
          ctl[7] ? {ctl[13], ctl[12], ctl[10], ctl[11]} : w[3:0];
      cmp_bit("terminalReadyN", ~ctl[10], dtrN);
      cmp_bit("auxModemPinAN", ~ctl[12], auxAN);
      cmp_bit("auxModemPinBN", ~ctl[13], auxBN);
      // Expected levels worked out apart to keep the calls short
      v[0] = ctl[14] ? ~w[4] : ~ctl[11];
      cmp_bit("requestToSendN", v[0], rtsN);
      cmp_word("coreModemSt", {28'h0, m}, {28'h0, modemSt});
      v[0] = ctl[0] & ctl[8] & (~ctl[15] | m[0]);
      cmp_bit("coreTxStartOk", v[0], txOk);
      cmp_bit("coreRxStartOk", ctl[0] & ctl[9], rxOk);
      rd(`UCEN_ST_OFF, {25'h0, ctl[1] & ctl[0], 2'b00, m});
    end
    // Frozen clock enable drops a write
    @(posedge core_clk);
    ce <= 1'b0;
    wr(`UCEN_CR_OFF, 32'h0000ff87);
    ce <= 1'b1;
    rd(`UCEN_CR_OFF, ctl);
    // Disable in mid-character: sections stay live until idle
    set_ctl(32'h301);
    @(posedge core_clk);
    {coreTxBusy, coreRxBusy} <= 2'b11;
    set_ctl(32'h0);
    settle(3);
    cmp_bit("coreTxRun", 1'b1, txRun);
    cmp_bit("coreRxRun", 1'b1, rxRun);
    cmp_bit("coreTxStartOk", 1'b0, txOk);
    @(posedge core_clk);
    {coreTxBusy, coreRxBusy} <= 2'b00;
    settle(3);
    cmp_bit("coreTxRun", 1'b0, txRun);
    cmp_bit("coreRxRun", 1'b0, rxRun);
    // Serial loopback passes both levels
    set_ctl(32'h381);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge core_clk);
      coreTxBit <= b[0];
      settle(3);
      cmp_bit("coreRxBit", b[0], rxBit);
      cmp_bit("serialTxPin", b[0], txPin);
    end
    // Infrared mode marks the serial pin and pulses three ticks, or three reference periods in low power
    @(posedge core_clk);
    modemReq <= 4'hf;
    set_ctl(32'h303);
    coreTxBit <= 1'b0;
    settle(8);
    cmp_bit("serialTxPin", 1'b1, txPin);
    cmp_word("coreModemSt", 32'h0, {28'h0, modemSt});
    ir_bit(0, 60, n);
    cmp_bit("normal pulse width", 1'b1, n >= 11 && n <= 13);
    set_ctl(32'h307);
    ir_bit(0, 100, n);
    cmp_bit("low-power pulse width", 1'b1, n >= 26 && n <= 33);
    // Light received only while infrared is enabled
    for (int s = 0; s < 2; s++)
    begin
      set_ctl(s ? 32'h303 : 32'h301);
      @(posedge core_clk);
      irFlash <= 1'b1;
      @(posedge core_clk);
      irFlash <= 1'b0;
      ir_bit(1, 20, n);
      cmp_bit("decoded low bit", s[0], n > 0);
    end
    set_ctl(32'h301);
    ir_bit(0, 60, n);
    cmp_bit("dark output", 1'b1, n == 0);
    // Infrared loopback with the test override, cleared afterwards
    set_ctl(32'h383);
    wr(`UCEN_TC_OFF, 32'h1);
    settle(70);
    ir_bit(1, 20, n);
    cmp_bit("looped light", 1'b1, n > 0);
    wr(`UCEN_TC_OFF, 32'h0);
    rd(`UCEN_TC_OFF, 32'h0);
    // Infrared enable has no effect with the port off
    set_ctl(32'h302);
    settle(4);
    cmp_bit("serialTxPin", 1'b0, txPin);
    ir_bit(0, 60, n);
    cmp_bit("idle infrared", 1'b1, n == 0);
    settle(4);
    complete_run();
  end
endmodule : tb_top
